/* ppgc_defs.vh */
// Constants for the pattern generator and checker block.
// Assumes inclusion by bare name from every design file of the block.
`ifndef PPGC_DEFS_VH
`define PPGC_DEFS_VH

// APB byte offsets
`define PPGC_OFF_CTRL     12'h000
`define PPGC_OFF_STATUS   12'h004
`define PPGC_OFF_IRQ_STAT 12'h008
`define PPGC_OFF_IRQ_MASK 12'h00c

// Control register fields
`define PPGC_CTRL_EN      0
`define PPGC_CTRL_MODE_LO 1
`define PPGC_CTRL_MODE_HI 3
`define PPGC_CTRL_W10     4
`define PPGC_CTRL_LPBK    5
`define PPGC_CTRL_TXRST   6
`define PPGC_CTRL_RXRST   7
`define PPGC_CTRL_RST     8'h00

// Status register fields
`define PPGC_ST_DONE      0
`define PPGC_ST_ERR       1
`define PPGC_ST_ACTIVE    2
`define PPGC_ST_ILLEGAL   3
`define PPGC_ST_BLOCKED   4
`define PPGC_ST_ALIGNED   5

// Interrupt status and mask fields
`define PPGC_IRQ_DONE     0
`define PPGC_IRQ_ERR      1
`define PPGC_IRQ_RST      2'h0

// Pattern modes
`define PPGC_MODE_PRBS7   3'h0
`define PPGC_MODE_PRBS8   3'h1
`define PPGC_MODE_PRBS10  3'h2
`define PPGC_MODE_PRBS23  3'h3
`define PPGC_MODE_HIFREQ  3'h4
`define PPGC_MODE_LOFREQ  3'h5

// Word aligner patterns
`define PPGC_ALIGN_PRBS7  16'h3040
`define PPGC_ALIGN_PRBS8  16'hff5a
`define PPGC_ALIGN_PRBS10 16'h03ff
`define PPGC_ALIGN_PRBS23 16'hffff

// Fixed patterns, first serial bit in bit 0
`define PPGC_HIFREQ_WORD  10'h155
`define PPGC_LOFREQ_WORD  10'h01f

// Sequence and checker counts
`define PPGC_SEED         23'h7fffff
`define PPGC_SEED_WORDS   21'h000003
`define PPGC_CYC_PRBS7    21'h000010
`define PPGC_CYC_PRBS8    21'h000020
`define PPGC_CYC_PRBS10   21'h000067
`define PPGC_ERR_HOLD     2'h3

`endif

/* ppgc_step.v */
// One word step of the sequence shift register, for generator and checker.
// Assumes the caller holds the state register; this module is combinational.
`timescale 1ns/10ps
`include "ppgc_defs.vh"
module ppgc_step (
  // Configuration
  input  wire [2:0]  i_mode,
  input  wire        i_width10,
  // State and word to shift in
  input  wire [22:0] i_state,
  input  wire [9:0]  i_word,
  // Results
  output wire [9:0]  o_pred,
  output wire [22:0] o_next
);

  function fb_bit;
    input [2:0]  mode;
    input [22:0] st;
    begin
      case (mode)
        `PPGC_MODE_PRBS7:  fb_bit = st[6] ^ st[5];
        `PPGC_MODE_PRBS8:  fb_bit = st[7] ^ st[6];
        `PPGC_MODE_PRBS10: fb_bit = st[9] ^ st[6];
        default:           fb_bit = st[22] ^ st[17];
      endcase
    end
  endfunction

  // Serial bits advance one at a time, bit 0 sent first
  function [9:0] pred_word;
    input [2:0]  mode;
    input        w10;
    input [22:0] st;
    integer      i;
    reg   [22:0] s;
    reg          b;
    begin
      s = st;
      pred_word = 10'h000;
      for (i = 0; i < 10; i = i + 1) begin
        if (i < 8 || w10) begin
          b = fb_bit(mode, s);
          pred_word[i] = b;
          s = {s[21:0], b};
        end
      end
      if (mode == `PPGC_MODE_HIFREQ)
        pred_word = w10 ? `PPGC_HIFREQ_WORD : (`PPGC_HIFREQ_WORD & 10'h0ff);
      else if (mode == `PPGC_MODE_LOFREQ)
        pred_word = `PPGC_LOFREQ_WORD;
    end
  endfunction

  function [22:0] shift_in;
    input        w10;
    input [22:0] st;
    input [9:0]  word;
    integer      i;
    begin
      shift_in = st;
      for (i = 0; i < 10; i = i + 1) begin
        if (i < 8 || w10)
          shift_in = {shift_in[21:0], word[i]};
      end
    end
  endfunction

  assign o_pred = pred_word(i_mode, i_width10, i_state);
  assign o_next = shift_in(i_width10, i_state, i_word);

endmodule

/* ppgc_err_hold.v */
// Error flag of the checker with minimum hold and per-sequence clearing.
// Assumes i_seq_end pulses on the last word of each received sequence.
`timescale 1ns/10ps
`include "ppgc_defs.vh"
module ppgc_err_hold (
  // Clock and reset
  input  wire i_ref_clk,
  input  wire i_rst,
  // Events
  input  wire i_enable,
  input  wire i_mismatch,
  input  wire i_seq_end,
  // Flag
  output reg  o_err
);

  reg [1:0] hold;
  reg       seq_bad;

  always @(posedge i_ref_clk) begin
    if (i_rst || !i_enable) begin
      o_err   <= 1'b0;
      hold    <= 2'h0;
      seq_bad <= 1'b0;
    end else begin
      if (i_mismatch) begin
        o_err <= 1'b1;
        hold  <= `PPGC_ERR_HOLD;
      end else begin
        if (hold != 2'h0)
          hold <= hold - 2'h1;
        if (i_seq_end && !seq_bad && hold == 2'h0)
          o_err <= 1'b0;
      end
      if (i_seq_end)
        seq_bad <= i_mismatch;
      else
        seq_bad <= seq_bad | i_mismatch;
    end
  end

endmodule

/* ppgc_top.v */
// Pattern generator and checker for one transceiver channel, APB registers.
// Assumes the serializer takes o_ser_data each clock and the word aligner
// drives i_rx_data and i_rx_aligned on the same clock.
`timescale 1ns/10ps
`include "ppgc_defs.vh"
module ppgc_top #(
  parameter [20:0] P_PRBS23_CYCLE_WORDS = 21'h100000
) (
  // Clock and reset
  input  wire        i_ref_clk,
  input  wire        i_rst,
  // APB slave
  input  wire        i_psel,
  input  wire        i_penable,
  input  wire        i_pwrite,
  input  wire [11:0] i_paddr,
  input  wire [31:0] i_pwdata,
  output reg  [31:0] o_prdata,
  output wire        o_pready,
  output reg         o_pslverr,
  // Channel configuration
  input  wire        i_basic_mode,
  // Transmit coding layer
  input  wire [9:0]  i_tx_data,
  output reg  [9:0]  o_ser_data,
  output wire        o_tx_width10,
  // Receive coding layer
  input  wire [9:0]  i_rx_data,
  input  wire        i_rx_aligned,
  output reg  [15:0] o_align_pattern,
  output wire        o_serial_loopback,
  // Status
  output wire        o_rx_done,
  output wire        o_rx_err,
  output wire        o_irq
);

  localparam [3:0] CK_IDLE = 4'h1;
  localparam [3:0] CK_SEED = 4'h2;
  localparam [3:0] CK_HUNT = 4'h4;
  localparam [3:0] CK_DONE = 4'h8;

  // Registers
  reg  [7:0]  ctrl;
  reg  [1:0]  irq_stat;
  reg  [1:0]  irq_mask;
  reg  [1:0]  next_irq_stat;

  // Generator
  reg  [22:0] gen_state;
  wire [9:0]  gen_word;
  wire [22:0] gen_next;

  // Checker
  reg  [3:0]  ck_state;
  reg  [3:0]  next_ck_state;
  reg  [20:0] ck_cnt;
  reg  [20:0] next_ck_cnt;
  reg  [22:0] ck_hist;
  wire [9:0]  ck_pred;
  wire [22:0] ck_next;
  wire        ck_err;
  reg         done_q;
  reg         err_q;

  // Control decode
  wire [2:0]  mode;
  wire        w10;
  wire        legal;
  wire        active;
  wire        checkable;
  wire        tx_rst;
  wire        rx_rst;
  wire [9:0]  rx_mask;
  wire [9:0]  rx_word;
  wire        mismatch;
  wire [20:0] cyc_words;
  wire        cyc_last;
  wire        seq_end;

  // APB decode
  wire        setup;
  wire        wr;
  wire        mapped;
  wire [1:0]  w1c;

  function mode_legal;
    input [2:0] m;
    input       wide;
    begin
      case (m)
        `PPGC_MODE_PRBS7:  mode_legal = !wide;
        `PPGC_MODE_PRBS8:  mode_legal = !wide;
        `PPGC_MODE_PRBS10: mode_legal = wide;
        `PPGC_MODE_PRBS23: mode_legal = !wide;
        `PPGC_MODE_HIFREQ: mode_legal = 1'b1;
        `PPGC_MODE_LOFREQ: mode_legal = wide;
        default:           mode_legal = 1'b0;
      endcase
    end
  endfunction

  function [20:0] cycle_words;
    input [2:0] m;
    begin
      case (m)
        `PPGC_MODE_PRBS7:  cycle_words = `PPGC_CYC_PRBS7;
        `PPGC_MODE_PRBS8:  cycle_words = `PPGC_CYC_PRBS8;
        `PPGC_MODE_PRBS10: cycle_words = `PPGC_CYC_PRBS10;
        default:           cycle_words = P_PRBS23_CYCLE_WORDS;
      endcase
    end
  endfunction

  function is_off;
    input [11:0] addr;
    input [11:0] off;
    begin
      is_off = (addr == off);
    end
  endfunction

  assign mode      = ctrl[`PPGC_CTRL_MODE_HI:`PPGC_CTRL_MODE_LO];
  assign w10       = ctrl[`PPGC_CTRL_W10];
  assign legal     = mode_legal(mode, w10);
  // Test only runs in basic functional mode with a legal pattern
  assign active    = ctrl[`PPGC_CTRL_EN] & i_basic_mode & legal;
  assign checkable = active & ~mode[2];
  assign tx_rst    = i_rst | ctrl[`PPGC_CTRL_TXRST] | ~active;
  assign rx_rst    = i_rst | ctrl[`PPGC_CTRL_RXRST] | ~checkable;

  assign o_tx_width10      = w10;
  assign o_serial_loopback = ctrl[`PPGC_CTRL_LPBK] & active;

  // ---------------- APB slave ----------------
  assign setup    = i_psel & ~i_penable;
  assign o_pready = i_psel & i_penable;
  assign wr       = o_pready & i_pwrite;
  assign mapped   = is_off(i_paddr, `PPGC_OFF_CTRL) |
                    is_off(i_paddr, `PPGC_OFF_STATUS) |
                    is_off(i_paddr, `PPGC_OFF_IRQ_STAT) |
                    is_off(i_paddr, `PPGC_OFF_IRQ_MASK);
  assign w1c      = (wr && is_off(i_paddr, `PPGC_OFF_IRQ_STAT)) ?
                    i_pwdata[1:0] : 2'h0;

  // Read data and error are captured in setup, valid in access
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_prdata  <= 32'h00000000;
      o_pslverr <= 1'b0;
    end else if (setup) begin
      o_pslverr <= ~mapped;
      o_prdata  <= 32'h00000000;
      if (!i_pwrite) begin
        if (is_off(i_paddr, `PPGC_OFF_CTRL))
          o_prdata <= {24'h000000, ctrl};
        else if (is_off(i_paddr, `PPGC_OFF_STATUS))
          o_prdata <= {26'h0000000, i_rx_aligned,
                       ctrl[`PPGC_CTRL_EN] & ~i_basic_mode,
                       ctrl[`PPGC_CTRL_EN] & ~legal,
                       active, o_rx_err, o_rx_done};
        else if (is_off(i_paddr, `PPGC_OFF_IRQ_STAT))
          o_prdata <= {30'h00000000, irq_stat};
        else if (is_off(i_paddr, `PPGC_OFF_IRQ_MASK))
          o_prdata <= {30'h00000000, irq_mask};
      end
    end
  end

  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      ctrl     <= `PPGC_CTRL_RST;
      irq_mask <= `PPGC_IRQ_RST;
    end else if (wr) begin
      if (is_off(i_paddr, `PPGC_OFF_CTRL))
        ctrl <= i_pwdata[7:0];
      if (is_off(i_paddr, `PPGC_OFF_IRQ_MASK))
        irq_mask <= i_pwdata[1:0];
    end
  end

  // ---------------- Interrupts ----------------
  // A new event in the clearing cycle stays set
  always @* begin
    next_irq_stat = irq_stat & ~w1c;
    if (o_rx_done && !done_q)
      next_irq_stat[`PPGC_IRQ_DONE] = 1'b1;
    if (o_rx_err && !err_q)
      next_irq_stat[`PPGC_IRQ_ERR] = 1'b1;
  end

  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      irq_stat <= `PPGC_IRQ_RST;
      done_q   <= 1'b0;
      err_q    <= 1'b0;
    end else begin
      irq_stat <= next_irq_stat;
      done_q   <= o_rx_done;
      err_q    <= o_rx_err;
    end
  end

  assign o_irq = |(irq_stat & irq_mask);

  // ---------------- Generator ----------------
  ppgc_step u_gen_step (
    .i_mode    (mode),
    .i_width10 (w10),
    .i_state   (gen_state),
    .i_word    (gen_word),
    .o_pred    (gen_word),
    .o_next    (gen_next)
  );

  // Free-running register wraps through the full sequence
  always @(posedge i_ref_clk) begin
    if (tx_rst)
      gen_state <= `PPGC_SEED;
    else
      gen_state <= gen_next;
  end

  // Pattern takes the place of coded data ahead of the serializer
  always @(posedge i_ref_clk) begin
    if (i_rst)
      o_ser_data <= 10'h000;
    else if (active)
      o_ser_data <= gen_word;
    else
      o_ser_data <= i_tx_data;
  end

  // Aligner pattern for the selected sequence
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_align_pattern <= 16'h0000;
    end else begin
      case (mode)
        `PPGC_MODE_PRBS7:  o_align_pattern <= `PPGC_ALIGN_PRBS7;
        `PPGC_MODE_PRBS8:  o_align_pattern <= `PPGC_ALIGN_PRBS8;
        `PPGC_MODE_PRBS10: o_align_pattern <= `PPGC_ALIGN_PRBS10;
        `PPGC_MODE_PRBS23: o_align_pattern <= `PPGC_ALIGN_PRBS23;
        default:           o_align_pattern <= 16'h0000;
      endcase
    end
  end

  // ---------------- Checker ----------------
  assign rx_mask   = w10 ? 10'h3ff : 10'h0ff;
  assign rx_word   = i_rx_data & rx_mask;
  assign mismatch  = i_rx_aligned && (rx_word != ck_pred);
  assign cyc_words = cycle_words(mode);
  assign cyc_last  = (ck_cnt == cyc_words - 21'h000001);
  assign seq_end   = (ck_state == CK_DONE) && cyc_last;

  ppgc_step u_ck_step (
    .i_mode    (mode),
    .i_width10 (w10),
    .i_state   (ck_hist),
    .i_word    (rx_word),
    .o_pred    (ck_pred),
    .o_next    (ck_next)
  );

  // History of received bits predicts the next word
  always @(posedge i_ref_clk) begin
    if (rx_rst)
      ck_hist <= 23'h000000;
    else if (i_rx_aligned)
      ck_hist <= ck_next;
  end

  always @* begin
    next_ck_state = ck_state;
    next_ck_cnt   = ck_cnt;
    case (ck_state)
      CK_IDLE: begin
        next_ck_cnt = 21'h000000;
        if (i_rx_aligned)
          next_ck_state = CK_SEED;
      end
      CK_SEED: begin
        if (!i_rx_aligned) begin
          next_ck_state = CK_IDLE;
        end else if (ck_cnt == `PPGC_SEED_WORDS - 21'h000001) begin
          next_ck_state = CK_HUNT;
          next_ck_cnt   = 21'h000000;
        end else begin
          next_ck_cnt = ck_cnt + 21'h000001;
        end
      end
      CK_HUNT: begin
        if (!i_rx_aligned) begin
          next_ck_state = CK_IDLE;
        end else if (mismatch) begin
          next_ck_state = CK_SEED;
          next_ck_cnt   = 21'h000000;
        end else if (cyc_last) begin
          next_ck_state = CK_DONE;
          next_ck_cnt   = 21'h000000;
        end else begin
          next_ck_cnt = ck_cnt + 21'h000001;
        end
      end
      CK_DONE: begin
        // Done stays until the receive reset
        next_ck_cnt = cyc_last ? 21'h000000 : ck_cnt + 21'h000001;
      end
      default: begin
        next_ck_state = CK_IDLE;
        next_ck_cnt   = 21'h000000;
      end
    endcase
  end

  always @(posedge i_ref_clk) begin
    if (rx_rst) begin
      ck_state <= CK_IDLE;
      ck_cnt   <= 21'h000000;
    end else begin
      ck_state <= next_ck_state;
      ck_cnt   <= next_ck_cnt;
    end
  end

  ppgc_err_hold u_err_hold (
    .i_ref_clk  (i_ref_clk),
    .i_rst      (rx_rst),
    .i_enable   (ck_state == CK_DONE),
    .i_mismatch (mismatch),
    .i_seq_end  (seq_end),
    .o_err      (ck_err)
  );

  assign o_rx_done = (ck_state == CK_DONE);
  assign o_rx_err  = ck_err;

endmodule

/* ppgc_link_model.sv */
// Loopback path and word aligner model at the far side of the block.
// Assumes the bench pulses i_inject to corrupt one received word.
`timescale 1ns/10ps
module ppgc_link_model (
  // Clock and reset
  input  wire       i_ref_clk,
  input  wire       i_rst,
  // From the block
  input  wire [9:0] i_ser_data,
  input  wire       i_loopback,
  // Bench command
  input  wire       i_inject,
  // To the block
  output reg  [9:0] o_rx_data,
  output reg        o_rx_aligned
);
  reg [2:0] lock_cnt;
  initial o_rx_data = 10'h2aa;
  initial o_rx_aligned = 1'b0;
  always @(posedge i_ref_clk) begin
    if (i_rst || !i_loopback) begin
      lock_cnt     <= 3'h0;
      o_rx_aligned <= 1'b0;
      o_rx_data    <= ~o_rx_data;
    end else begin
      lock_cnt     <= (lock_cnt == 3'h4) ? lock_cnt : lock_cnt + 3'h1;
      o_rx_aligned <= (lock_cnt == 3'h4);
      o_rx_data    <= i_ser_data ^ {9'h0, i_inject};
    end
  end
endmodule

/* ppgc_sva.sv */
// Port-level checks of the pattern block.
// Assumes one clock domain and the synchronous reset of the block.
`timescale 1ns/10ps
module ppgc_sva (
  // Clock and reset
  input wire        i_ref_clk,
  input wire        i_rst,
  // Inputs watched
  input wire        i_psel,
  input wire        i_penable,
  input wire        i_pwrite,
  input wire [11:0] i_paddr,
  input wire        i_basic_mode,
  input wire        i_rx_aligned,
  // Outputs watched
  input wire [31:0] o_prdata,
  input wire        o_pready,
  input wire        o_pslverr,
  input wire [9:0]  o_ser_data,
  input wire [15:0] o_align_pattern,
  input wire        o_rx_done,
  input wire        o_rx_err,
  input wire        o_irq
);
  reg  [7:0] algn_cnt;
  wire       apb_wr = i_psel && i_penable && i_pwrite;
  wire       setup  = i_psel && !i_penable;
  always @(posedge i_ref_clk) begin
    if (i_rst || !i_rx_aligned)
      algn_cnt <= 8'h00;
    else if (algn_cnt != 8'hff)
      algn_cnt <= algn_cnt + 8'h01;
  end
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  property p_pready; o_pready == (i_psel && i_penable); endproperty
  a_pready: assert property (p_pready) else $error("pready wrong");
  property p_slverr;
    setup |=> o_pslverr == $past(i_paddr[11:4] != 8'h00 || i_paddr[1:0] != 2'h0);
  endproperty
  a_slverr: assert property (p_slverr) else $error("slverr wrong");
  property p_rdata; setup && !i_pwrite && i_paddr[11:4] != 8'h00 |=> o_prdata == 32'h0;
  endproperty
  a_rdata: assert property (p_rdata) else $error("unmapped read data");
  property p_rst;
    disable iff (1'b0) i_rst |=> !o_rx_done && !o_rx_err && !o_irq && o_ser_data == 10'h0
      && o_align_pattern == 16'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("reset outputs");
  property p_done_fall;
    $fell(o_rx_done) |-> $past(apb_wr) || $past(apb_wr, 2) || $past(!i_basic_mode)
      || $past(i_rst);
  endproperty
  a_done_fall: assert property (p_done_fall) else $error("done dropped");
  property p_err_done; $rose(o_rx_err) |-> o_rx_done; endproperty
  a_err_done: assert property (p_err_done) else $error("error before done");
  property p_err_hold; $rose(o_rx_err) |=> o_rx_err [*2]; endproperty
  a_err_hold: assert property (p_err_hold) else $error("error too short");
  property p_done_algn; $rose(o_rx_done) |-> algn_cnt >= 8'h13; endproperty
  a_done_algn: assert property (p_done_algn) else $error("done too early");
  property p_irq_fall; $fell(o_irq) |-> $past(apb_wr) || $past(i_rst); endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq dropped");
endmodule
bind ppgc_top ppgc_sva i_ppgc_sva (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
  .i_basic_mode(i_basic_mode), .i_rx_aligned(i_rx_aligned), .o_prdata(o_prdata),
  .o_pready(o_pready), .o_pslverr(o_pslverr), .o_ser_data(o_ser_data),
  .o_align_pattern(o_align_pattern), .o_rx_done(o_rx_done), .o_rx_err(o_rx_err),
  .o_irq(o_irq));

/* ppgc_top_tb.sv */
// Self-checking bench of the pattern block with a loopback link model.
// Assumes zero-wait APB and a shortened long-sequence cycle count.
`timescale 1ns/10ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin miscompares++; $display("unexpected %s exp %h got %h", n, e, g); end end
module ppgc_top_tb;
  reg         i_ref_clk = 1'b0;
  reg         i_rst = 1'b1;
  reg         i_psel = 1'b0;
  reg         i_penable = 1'b0;
  reg         i_pwrite = 1'b0;
  reg  [11:0] i_paddr = 12'h000;
  reg  [31:0] i_pwdata = 32'h0;
  reg         i_basic_mode = 1'b1;
  reg  [9:0]  i_tx_data = 10'h000;
  reg         inject = 1'b0;
  wire [31:0] o_prdata;
  wire        o_pready, o_pslverr, o_tx_width10, o_serial_loopback;
  wire        o_rx_done, o_rx_err, o_irq, i_rx_aligned;
  wire [9:0]  o_ser_data, i_rx_data;
  wire [15:0] o_align_pattern;
  integer     miscompares = 0;
  integer     check_count = 0;
  integer     cycles = 0;
  integer     k, m, n, t;
  reg  [9:0]  tx_q;
  reg  [31:0] rd;
  reg         er;
  reg  [14:0] e;
  reg         q[$];
  reg  [9:0]  w0 [0:3];
  integer     tapn [0:3] = '{7, 8, 10, 23};
  integer     tapm [0:3] = '{6, 7, 7, 18};
  reg  [15:0] al [0:3] = '{16'h3040, 16'hff5a, 16'h03ff, 16'hffff};
  // Mode, width, passthrough and fixed word of each refusal or fixed case
  reg  [14:0] fx [0:7] = '{15'h1055, 15'h3155, 15'h341f, 15'h5400, 15'h4800, 15'h6000,
                            15'h6c00, 15'h5800};
  ppgc_top #(.P_PRBS23_CYCLE_WORDS(21'h000040)) i_ppgc_top (.i_ref_clk(i_ref_clk),
    .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
    .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
    .o_pslverr(o_pslverr), .i_basic_mode(i_basic_mode), .i_tx_data(i_tx_data),
    .o_ser_data(o_ser_data), .o_tx_width10(o_tx_width10), .i_rx_data(i_rx_data),
    .i_rx_aligned(i_rx_aligned), .o_align_pattern(o_align_pattern),
    .o_serial_loopback(o_serial_loopback), .o_rx_done(o_rx_done), .o_rx_err(o_rx_err),
    .o_irq(o_irq));
  ppgc_link_model i_ppgc_link_model (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
    .i_ser_data(o_ser_data), .i_loopback(o_serial_loopback), .i_inject(inject),
    .o_rx_data(i_rx_data), .o_rx_aligned(i_rx_aligned));
  initial forever #4 i_ref_clk = ~i_ref_clk;
  task end_sim;
    if (miscompares == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(posedge i_ref_clk) begin
    i_tx_data <= 10'($urandom);
    tx_q <= i_tx_data;
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      miscompares++;
      end_sim;
    end
  end
  task apb(input w, input [11:0] a, input [31:0] d);
    @(posedge i_ref_clk);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_ref_clk);
    i_penable <= 1'b1;
    @(posedge i_ref_clk);
    while (o_pready !== 1'b1) @(posedge i_ref_clk);
    rd = o_prdata;
    er = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    // Let the write land before callers look at outputs
    @(negedge i_ref_clk);
  endtask
  function [31:0] ctl(input [2:0] md, input w, input l);
    ctl = {26'h0, l, w, md, 1'b1};
  endfunction
  // Bounded wait on done (sel 0) or error (sel 1)
  task ws(input sel, input v);
    for (t = 0; t < 300 && (sel ? o_rx_err : o_rx_done) !== v; t++) @(posedge i_ref_clk);
  endtask
  // Serial bit stream must obey the feedback recurrence
  task gen(input integer nb, input integer mb, input w);
    q.delete();
    repeat (4) @(posedge i_ref_clk);
    for (k = 0; k < 40; k++) begin
      @(negedge i_ref_clk);
      for (m = 0; m < (w ? 10 : 8); m++) q.push_back(o_ser_data[m]);
    end
    for (k = nb; k < q.size(); k++) `CHK("prbs bit", q[k-nb] ^ q[k-mb], q[k])
    t = 0;
    foreach (q[k]) t += q[k];
    `CHK("prbs ones", 1'b1, t > 0)
    if (nb == 7)
      for (k = 127; k < q.size(); k++) `CHK("period", q[k-127], q[k])
  endtask
  initial begin
    void'($urandom(65786));
    repeat (5) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    for (n = 0; n < 16; n += 4) begin
      apb(1'b0, n[11:0], 32'h0);
      `CHK("reset value", 32'h0, rd)
    end
    apb(1'b0, 12'h010, 32'h0);
    `CHK("unmapped err", 1'b1, er)
    `CHK("unmapped data", 32'h0, rd)
    apb(1'b1, 12'h020, 32'hffffffff);
    `CHK("unmapped write", 1'b1, er)
    apb(1'b1, 12'h00c, 32'h3);
    apb(1'b0, 12'h00c, 32'h0);
    `CHK("mask", 32'h3, rd)
    for (n = 0; n < 4; n++) begin
      apb(1'b1, 12'h000, ctl(n[2:0], n == 2, 1'b0));
      gen(tapn[n], tapm[n], n == 2);
      `CHK("align", al[n], o_align_pattern)
      `CHK("width", n == 2, o_tx_width10)
      apb(1'b1, 12'h000, ctl(n[2:0], n == 2, 1'b1));
      `CHK("loopback", 1'b1, o_serial_loopback)
      ws(1'b0, 1'b1);
      `CHK("done", 1'b1, o_rx_done)
      apb(1'b0, 12'h004, 32'h0);
      `CHK("status", 6'h25, rd[5:0])
      apb(1'b1, 12'h000, 32'h0);
    end
    `CHK("irq", 1'b1, o_irq)
    apb(1'b0, 12'h008, 32'h0);
    `CHK("irq status", 32'h1, rd)
    apb(1'b1, 12'h008, 32'h1);
    `CHK("irq cleared", 1'b0, o_irq)
    apb(1'b1, 12'h00c, 32'h2);
    apb(1'b1, 12'h000, ctl(3'h0, 1'b0, 1'b1));
    ws(1'b0, 1'b1);
    @(negedge i_ref_clk);
    `CHK("irq masked", 1'b0, o_irq)
    @(posedge i_ref_clk);
    inject <= 1'b1;
    @(posedge i_ref_clk);
    inject <= 1'b0;
    ws(1'b1, 1'b1);
    `CHK("err", 1'b1, o_rx_err)
    repeat (2) @(posedge i_ref_clk);
    `CHK("err irq", 1'b1, o_irq)
    ws(1'b1, 1'b0);
    `CHK("err clear", 1'b0, o_rx_err)
    `CHK("done held", 1'b1, o_rx_done)
    apb(1'b0, 12'h008, 32'h0);
    `CHK("irq status", 32'h3, rd)
    apb(1'b1, 12'h008, 32'h3);
    `CHK("irq w1c", 1'b0, o_irq)
    apb(1'b1, 12'h000, ctl(3'h0, 1'b0, 1'b1) | 32'h80);
    repeat (2) @(posedge i_ref_clk);
    `CHK("rx reset", 1'b0, o_rx_done)
    apb(1'b1, 12'h000, ctl(3'h0, 1'b0, 1'b1));
    ws(1'b0, 1'b1);
    `CHK("rx restart", 1'b1, o_rx_done)
    for (n = 0; n < 2; n++) begin
      apb(1'b1, 12'h000, ctl(3'h0, 1'b0, 1'b0) | 32'h40);
      repeat (20) @(posedge i_ref_clk);
      apb(1'b1, 12'h000, ctl(3'h0, 1'b0, 1'b0));
      for (k = 0; k < 4; k++) begin
        @(negedge i_ref_clk);
        if (n == 0) w0[k] = o_ser_data;
        else `CHK("tx restart", w0[k], o_ser_data)
      end
    end
    for (n = 0; n < 8; n++) begin
      e = fx[n];
      apb(1'b1, 12'h000, ctl(e[12:10], e[13], 1'b1));
      repeat (30) @(posedge i_ref_clk);
      @(negedge i_ref_clk);
      if (e[14]) `CHK("passthrough", tx_q[7:0], o_ser_data[7:0])
      else `CHK("fixed word", e[9:0], o_ser_data)
      `CHK("no verify", 1'b0, o_rx_done | o_rx_err)
      `CHK("loop gate", ~e[14], o_serial_loopback)
      apb(1'b0, 12'h004, 32'h0);
      `CHK("illegal", e[14], rd[3])
    end
    @(posedge i_ref_clk);
    i_basic_mode <= 1'b0;
    apb(1'b1, 12'h000, ctl(3'h0, 1'b0, 1'b0));
    repeat (3) @(posedge i_ref_clk);
    @(negedge i_ref_clk);
    `CHK("basic only", tx_q[7:0], o_ser_data[7:0])
    apb(1'b0, 12'h004, 32'h0);
    `CHK("blocked", 1'b1, rd[4])
    end_sim;
  end
endmodule
